// ### hdl/host_port_pkg.sv
// Constants shared by the host byte port and the fabric reader ends.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
// Notes on behaviour
// - Host waits for configuration before transactions
// - Configuration ends about 1 us after reset
// - Read at address zero returns ID low byte
// - Read request: write-select high, strobe low, one cycle
// - Read answer: data plus one-cycle low acknowledge
// - RAM window writes acknowledged and stored
// - Bytes stored into RAM bit-reversed
// - 0x10000 and 0x10001 are words 0 and 1
// - Next address pair selects the other RAM
// - Alternate pairs map to consecutive same-RAM words
// - Write to 0x08001 lands reversed in status
// - Fabric reads with enable high and address
// - Fabric holds enable for eight cycles
package host_port_pkg;
  localparam int addr_w = 18;
  localparam int data_w = 8;
  localparam int ram_addr_w = 8;
  localparam logic [17:0] id_addr = 18'h00000;
  localparam logic [17:0] status_addr = 18'h08001;
  localparam logic [17:0] ram_base = 18'h10000;
  localparam logic [17:0] ram_mask = 18'h30000;
  localparam int bank_bit = 1;
  // Arbitrary identity value, not any real part code
  localparam logic [7:0] device_id_low = 8'h5a;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] fill_done_value = 8'h55;
  localparam int config_time_ns = 1000;
  localparam int clock_period_ns = 25;
  localparam int config_cycles = (config_time_ns + clock_period_ns - 1)
    / clock_period_ns;
  localparam int read_burst = 8;

  function automatic logic [7:0] reverse_byte(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction
endpackage

// ### hdl/host_port_if.sv
// Host byte port signals between the external host and the device.
// Assumes both ends share clock; data bus split into in/out/enable.
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  import host_port_pkg::*;
  logic [addr_w-1:0] addr;
  logic rd_wr_n;
  logic strobe_n;
  logic [data_w-1:0] data_to_dev;
  logic [data_w-1:0] data_from_dev;
  logic data_oe;
  logic host_xfer_ack_n;
  modport device (
    input addr, rd_wr_n, strobe_n, data_to_dev,
    output data_from_dev, data_oe, host_xfer_ack_n
  );
  modport host (
    output addr, rd_wr_n, strobe_n, data_to_dev,
    input data_from_dev, data_oe, host_xfer_ack_n
  );
endinterface
`default_nettype wire

// ### hdl/host_byte_port_device.sv
// Device end: host port decode, two RAM banks, fill status register.
// Assumes the host obeys the configuration wait; fabric reads bank 0.
`timescale 1ns/1ps
`default_nettype none
module host_byte_port_device
  import host_port_pkg::*;
#(
  parameter int depth = 256
)
(
  input wire logic clock,
  input wire logic rst_n,
  host_port_if.device hp,
  input wire logic ram_read_en,
  input wire logic [host_port_pkg::ram_addr_w-1:0] ram_read_addr,
  output logic [host_port_pkg::data_w-1:0] ram_read_word,
  output logic [host_port_pkg::data_w-1:0] fill_done_status_reg,
  output logic config_done
);
  import host_port_pkg::*;
  // Word index is ram_addr_w bits wide, so deeper banks cannot be reached
  if (depth < 2 || depth > (1 << ram_addr_w))
  begin : g_bad_depth
    $error("depth out of range");
  end

  logic [data_w-1:0] bank0 [depth];
  logic [data_w-1:0] bank1 [depth];
  logic [15:0] config_count;
  logic req;
  logic in_window;
  logic bank_sel;
  logic [ram_addr_w-1:0] word_index;

  // Requests before configuration are ignored, not answered
  assign req = !hp.strobe_n && config_done;
  assign in_window = (hp.addr & ram_mask) == ram_base;
  // Bit 1 picks the bank; low bit plus bits above form the word
  assign bank_sel = hp.addr[bank_bit];
  // Upper address bits above the 8-bit word index alias onto lower words
  assign word_index =
    ram_addr_w'({hp.addr[addr_w-1:2], hp.addr[0]});

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      config_count <= 16'h0000;
    else if (!config_done)
      config_count <= config_count + 16'h0001;
  end
  assign config_done = config_count >= 16'(config_cycles);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hp.host_xfer_ack_n <= 1'b1;
      hp.data_oe <= 1'b0;
      hp.data_from_dev <= 8'h00;
    end
    else
    begin
      hp.host_xfer_ack_n <= !req;
      hp.data_oe <= req && hp.rd_wr_n;
      if (req && hp.rd_wr_n)
      begin
        if (hp.addr == id_addr)
          hp.data_from_dev <= device_id_low;
        else if (hp.addr == status_addr)
          hp.data_from_dev <= fill_done_status_reg;
        else
          hp.data_from_dev <= 8'h00;
      end
    end
  end

  // RAM writes; words beyond depth are dropped
  always_ff @(posedge clock)
  begin
    // Compare as int: a full 256-word bank would wrap an 8-bit bound to 0
    if (req && !hp.rd_wr_n && in_window && int'(word_index) < depth)
    begin
      if (bank_sel)
        bank1[word_index] <= reverse_byte(hp.data_to_dev);
      else
        bank0[word_index] <= reverse_byte(hp.data_to_dev);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fill_done_status_reg <= status_reset;
    else if (req && !hp.rd_wr_n && hp.addr == status_addr)
      fill_done_status_reg <= reverse_byte(hp.data_to_dev);
  end

  // Registered read port, bank 0 only, like a block RAM
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ram_read_word <= 8'h00;
    else if (ram_read_en && int'(ram_read_addr) < depth)
      ram_read_word <= bank0[ram_read_addr];
  end
endmodule
`default_nettype wire

// ### hdl/host_byte_port_host.sv
// Host end plus fabric reader: issues one byte request per command,
// then the fabric reads eight words once the status shows done.
`timescale 1ns/1ps
`default_nettype none
module host_byte_port_host
  import host_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  host_port_if.host hp,
  input wire logic config_done,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [host_port_pkg::addr_w-1:0] cmd_addr,
  input wire logic [host_port_pkg::data_w-1:0] cmd_data,
  output logic cmd_ready,
  output logic [host_port_pkg::data_w-1:0] rsp_data,
  output logic rsp_valid,
  input wire logic [host_port_pkg::data_w-1:0] fill_done_status_reg,
  input wire logic [host_port_pkg::data_w-1:0] ram_read_word,
  output logic ram_read_en,
  output logic [host_port_pkg::ram_addr_w-1:0] ram_read_addr,
  output logic [host_port_pkg::data_w-1:0] fabric_word,
  output logic fabric_word_valid
);
  import host_port_pkg::*;
  typedef enum logic [1:0] {idle, strobe, wait_ack} state_t;
  state_t state;
  logic [3:0] burst_count;
  logic burst_done;
  logic read_pending;

  // Nothing is issued until configuration completes
  assign cmd_ready = (state == idle) && config_done;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= idle;
      hp.addr <= 18'h00000;
      hp.rd_wr_n <= 1'b1;
      hp.strobe_n <= 1'b1;
      hp.data_to_dev <= 8'h00;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        idle:
          if (cmd_valid && cmd_ready)
          begin
            hp.addr <= cmd_addr;
            hp.rd_wr_n <= !cmd_write;
            hp.data_to_dev <= cmd_data;
            hp.strobe_n <= 1'b0;
            state <= strobe;
          end
        strobe:
        begin
          hp.strobe_n <= 1'b1;
          state <= wait_ack;
        end
        default:
          if (!hp.host_xfer_ack_n)
          begin
            rsp_data <= hp.data_from_dev;
            rsp_valid <= 1'b1;
            state <= idle;
          end
      endcase
    end
  end

  // Fabric side: one burst of reads after the done pattern lands
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burst_count <= 4'h0;
      burst_done <= 1'b0;
      ram_read_en <= 1'b0;
      ram_read_addr <= 8'h00;
    end
    else if (!burst_done && fill_done_status_reg == fill_done_value)
    begin
      ram_read_en <= 1'b1;
      ram_read_addr <= ram_addr_w'(burst_count);
      burst_count <= burst_count + 4'h1;
      if (burst_count == 4'(read_burst - 1))
        burst_done <= 1'b1;
    end
    else
      ram_read_en <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_pending <= 1'b0;
      fabric_word <= 8'h00;
      fabric_word_valid <= 1'b0;
    end
    else
    begin
      read_pending <= ram_read_en;
      fabric_word_valid <= read_pending;
      if (read_pending)
        fabric_word <= ram_read_word;
    end
  end
endmodule
`default_nettype wire

// ### bench/host_port_assertions.sv
// Checks on the host port wires between the two ends.
// Assumes one clock; instantiated beside the interface.
`timescale 1ns/1ps
`default_nettype none
module host_port_assertions
  import host_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [addr_w-1:0] addr,
  input wire logic rd_wr_n,
  input wire logic strobe_n,
  input wire logic [data_w-1:0] data_from_dev,
  input wire logic data_oe,
  input wire logic host_xfer_ack_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd_req = !strobe_n && rd_wr_n;
  property p_ack_next; !strobe_n |=> !host_xfer_ack_n; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack after request");
  property p_ack_pulse; !host_xfer_ack_n |=> host_xfer_ack_n; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  property p_oe_read; rd_req |=> data_oe && !host_xfer_ack_n; endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("read not answered");
  property p_no_oe_write; !strobe_n && !rd_wr_n |=> !data_oe; endproperty
  a_no_oe_write: assert property (p_no_oe_write)
    else $error("bus driven on write");
  property p_id;
    rd_req && addr == id_addr |=> data_from_dev == device_id_low;
  endproperty
  a_id: assert property (p_id)
    else $error("wrong id byte");
  property p_spacing; !strobe_n |=> strobe_n [*2]; endproperty
  a_spacing: assert property (p_spacing)
    else $error("strobe too long or too close");
  property p_ack_cause;
    $fell(host_xfer_ack_n) |-> $past(strobe_n) == 1'b0;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_oe_pulse; data_oe |-> !host_xfer_ack_n ##1 !data_oe; endproperty
  a_oe_pulse: assert property (p_oe_pulse)
    else $error("data drive not one cycle");
  c_read: cover property (rd_req ##1 data_oe);
  c_write: cover property (!strobe_n && !rd_wr_n ##1 !host_xfer_ack_n);
  c_status: cover property (!strobe_n && addr == status_addr);
endmodule
`default_nettype wire

// ### bench/host_byte_port_block_ram_path_bench.sv
// Bench joining host end and device end through the interface.
// Assumes the package constants; drives commands at falling edges.
`timescale 1ns/1ps
`default_nettype none
module host_byte_port_block_ram_path_bench;
  import host_port_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [addr_w-1:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic config_done, cmd_ready, rsp_valid, ram_read_en, fabric_word_valid;
  logic [7:0] rsp_data, fill_done_status_reg, ram_read_word;
  logic [7:0] ram_read_addr, fabric_word;
  int num_errors = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  host_port_if hp_if();
  host_byte_port_device u_host_byte_port_device (.clock(clock),
    .rst_n(rst_n), .hp(hp_if), .ram_read_en(ram_read_en),
    .ram_read_addr(ram_read_addr), .ram_read_word(ram_read_word),
    .fill_done_status_reg(fill_done_status_reg), .config_done(config_done));
  host_byte_port_host u_host_byte_port_host (.clock(clock), .rst_n(rst_n),
    .hp(hp_if), .config_done(config_done), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .fill_done_status_reg(fill_done_status_reg),
    .ram_read_word(ram_read_word), .ram_read_en(ram_read_en),
    .ram_read_addr(ram_read_addr), .fabric_word(fabric_word),
    .fabric_word_valid(fabric_word_valid));
  host_port_assertions u_host_port_assertions (.clock(clock), .rst_n(rst_n),
    .addr(hp_if.addr), .rd_wr_n(hp_if.rd_wr_n), .strobe_n(hp_if.strobe_n),
    .data_from_dev(hp_if.data_from_dev), .data_oe(hp_if.data_oe),
    .host_xfer_ack_n(hp_if.host_xfer_ack_n));
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  task automatic guard(input int n);
    if (n >= 200)
    begin
      num_errors++;
      close_out();
    end
  endtask
  // Waits for the host end to be idle, then offers one command
  task automatic send(input logic wr, input logic [addr_w-1:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    guard(n);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [addr_w-1:0] a, input logic [7:0] e);
    int n;
    send(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    guard(n);
    chk(rsp_data, e);
  endtask
  task automatic t_config;
    repeat (config_cycles - 10) @(negedge clock);
    chk({7'h00, cmd_ready}, 8'h00);
    chk({7'h00, config_done}, 8'h00);
    repeat (10) @(negedge clock);
    chk({7'h00, config_done}, 8'h01);
    chk({7'h00, cmd_ready}, 8'h01);
  endtask
  task automatic t_read;
    read_chk(id_addr, device_id_low);
    read_chk(18'h04000, 8'h00);
  endtask
  // Stray bank-one write after word 0 exposes a missing bank select
  task automatic t_fill;
    logic [addr_w-1:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = ram_base + 18'((i / 2) * 4 + i % 2);
      send(1'b1, a, {4'ha, a[3:0]});
      if (i == 0)
        send(1'b1, 18'h10002, 8'h3c);
    end
  endtask
  task automatic t_burst;
    int k;
    int n;
    logic [7:0] v;
    k = 0;
    n = 0;
    send(1'b1, status_addr, 8'haa);
    while (k < 8 && n < 200)
    begin
      @(negedge clock);
      n++;
      if (fabric_word_valid === 1'b1)
      begin
        v = {4'ha, 4'((k / 2) * 4 + k % 2)};
        v = {<<{v}};
        chk(fabric_word, v);
        k++;
      end
    end
    guard(n);
    // A ninth word would mean the enable stood too long
    @(negedge clock);
    chk({7'h00, fabric_word_valid}, 8'h00);
    chk(fill_done_status_reg, 8'h55);
    read_chk(status_addr, 8'h55);
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_config();
    t_read();
    t_fill();
    t_burst();
    close_out();
  end
endmodule
`default_nettype wire
